// ===== rtl/cell_measure_consts.vh
// constants for the cell measurement slot and filter logic
`ifndef CELL_MEASURE_CONSTS_VH
`define CELL_MEASURE_CONSTS_VH
`define CLK_PERIOD_NS 10
`define SLOT_TIME_NS 8000
`define SLOT_CYC (`SLOT_TIME_NS / `CLK_PERIOD_NS)
`define RR_SLOTS 24
`define RESULT_DEFAULT 16'h8000
`define TAG_DIE 5'h00
`define TAG_THERMISTOR_BIAS_REF 5'h01
`define TAG_CELL_BASE 5'h02
`define TAG_BUSBAR 5'h12
`define SLOT_GPIO 5'h13
`define TAG_GPIO_BASE 5'h18
`define IDX_BB 5'h10
`define IDX_DIE 5'h11
`define IDX_GPIO 5'h12
`define IDX_THERMISTOR_BIAS_REF 5'h1A
`define NUM_RES 27
`define MIN_CELLS 5'h06
`define MAX_CELLS 5'h10
`define PIN_ADC 3'h4
`define PIN_ADC_LIM 3'h5
`define FRAC_BITS 7
`define DIE_MAX 16'h1F40
`define DIE_MIN 16'hF060
`define PWR_ACTIVE 2'h0
`define PWR_SLEEP 2'h1
`define PWR_SHUTDOWN 2'h2
`endif

// ===== rtl/lpf_step.v
// one update step of the single-pole recursive result filter
`timescale 1ns/1ps
`include "cell_measure_consts.vh"
module lpf_step (
  input wire [15:0] sample,
  input wire [22:0] state,
  input wire [2:0] cutoff_sel,
  input wire load,
  output wire [22:0] state_nxt,
  output reg [15:0] result
);
  wire signed [23:0] x_ext;
  wire signed [23:0] s_ext;
  wire signed [23:0] diff;
  wire signed [23:0] step;
  wire signed [23:0] sum;
  wire signed [23:0] rnd;
  wire signed [16:0] q;
  wire [2:0] sh;
  // code 0 is the highest cutoff, coefficient halves per code up to code 6; code 7 repeats code 6
  assign sh = (cutoff_sel > 3'h6) ? 3'h7 : cutoff_sel + 3'h1;
  assign x_ext = {sample[15], sample, 7'h00};
  assign s_ext = {state[22], state};
  assign diff = x_ext - s_ext;
  assign step = diff >>> sh;
  // first sample after enable loads the state directly
  assign sum = load ? x_ext : s_ext + step;
  assign state_nxt = sum[22:0];
  // extra fraction is rounded off and saturated
  assign rnd = sum + 24'sh000040;
  assign q = rnd[23:`FRAC_BITS];
  always @* begin
    if (q > 17'sh07FFF)
      result = 16'h7FFF;
    else if (q < -17'sh08000)
      result = 16'h8000;
    else
      result = q[15:0];
  end
endmodule

// ===== rtl/result_fifo2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module result_fifo2 #(
  parameter W = 21
) (
  input wire ref_clk,
  input wire arst_n,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] cnt_r;
  reg [1:0] cnt_nxt;
  wire push;
  wire pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];
  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop)
      cnt_nxt = cnt_r + 2'h1;
    else if (pop & ~push)
      cnt_nxt = cnt_r - 2'h1;
  end
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
      in_ready <= 1'b0;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != 2'h2);
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
    end
  end
endmodule

// ===== rtl/cell_measure_lpf_slots.v
// slot sequencing, filtering and result registers of the main converter
//
// Operation
// - cell count from six to sixteen series cells is supported
// - level shifters are off in sleep and shutdown power modes
// - all sixteen cell slots stay in each cycle; inactive ones skipped
// - cell count field is the top active channel, lower ones active
// - active cell result is raw when filter off, filtered when on
// - inactive cell results stay at default and never update
// - seven cutoffs chosen by a three-bit select field
// - one cell cutoff setting applies to every cell filter
// - single-pole filter, coefficient 0.5 halving down to 1/128
// - each filter gets one sample per round-robin cycle
// - filter state loads the first sample after enabling
// - bus bar filter has its own cutoff select and enable
// - bus bar result raw when its filter off, filtered when on
// - die temperature is signed with zero meaning zero degrees
// - die temperature clamped between +200 and -100 degrees
// - die temperature also drives gain and offset correction
// - one general pin measured per cycle, all eight over eight cycles
// - pin measured only when configured as converter input
// - unconfigured pin slot skipped but kept in the cycle
// - each slot lasts 8 us, twenty-four slots make 192 us
// - results are 16-bit two's complement, high and low bytes
// - converter start resets every result to default first
// - after a high byte read the low byte holds until read
`timescale 1ns/1ps
`include "cell_measure_consts.vh"
module cell_measure_lpf_slots (
  input wire ref_clk,
  input wire arst_n,
  input wire adc_run,
  input wire [1:0] pwr_mode,
  input wire [3:0] highest_cell_count,
  input wire [2:0] cell_filter_cutoff_sel,
  input wire cell_filter_enable,
  input wire [2:0] busbar_filter_cutoff_sel,
  input wire busbar_filter_enable,
  input wire [23:0] pin_config_bank,
  output reg conv_start,
  output reg [4:0] conv_sel,
  input wire conv_valid,
  input wire [4:0] conv_tag,
  input wire [15:0] conv_data,
  output wire conv_ready,
  input wire [4:0] rd_sel,
  input wire rd_hi,
  input wire rd_lo,
  output reg [7:0] rd_data,
  output reg [15:0] level_shift_en,
  output reg [15:0] die_corr_temp,
  output reg rr_done
);
  // slot timer end points, cut to the counter widths
  localparam SLOT_LAST_W = `SLOT_CYC - 1;
  localparam SLOT_END_W = `RR_SLOTS - 1;
  localparam [9:0] SLOT_LAST = SLOT_LAST_W[9:0];
  localparam [4:0] SLOT_END = SLOT_END_W[4:0];

  reg run_d_r;
  reg [9:0] cyc_r;
  reg [4:0] slot_r;
  reg [2:0] gidx_r;
  reg [4:0] ncell_r;
  reg cell_en_r;
  reg bb_en_r;
  reg [2:0] cell_sel_r;
  reg [2:0] bb_sel_r;
  reg [23:0] pin_cfg_r;
  reg [15:0] res_r [0:`NUM_RES-1];
  reg [7:0] lo_r [0:`NUM_RES-1];
  reg [`NUM_RES-1:0] frz_r;
  reg [22:0] flt_r [0:16];
  reg [16:0] primed_r;
  reg [4:0] ncell_nxt;
  reg slot_act;
  reg [4:0] tag;
  reg [4:0] widx;
  reg wen;
  reg [15:0] wval;
  reg fsel;
  reg [4:0] fidx;
  reg [15:0] die_c;
  wire start;
  wire busy;
  wire pop_ready;
  wire pop_valid;
  wire [20:0] pop_data;
  wire [4:0] pop_tag;
  wire [15:0] pop_val;
  wire [2:0] pin_f;
  wire [22:0] f_state_nxt;
  wire [15:0] f_result;
  wire f_load;
  wire [2:0] f_sel;
  wire pop;
  wire [16:0] ls_mask;

  // effective cell count: code 0 means sixteen, small codes lift to six
  always @* begin
    if (highest_cell_count == 4'h0)
      ncell_nxt = `MAX_CELLS;
    else if ({1'b0, highest_cell_count} < `MIN_CELLS)
      ncell_nxt = `MIN_CELLS;
    else
      ncell_nxt = {1'b0, highest_cell_count};
  end

  assign start = adc_run & ~run_d_r;
  assign busy = rd_hi | rd_lo;
  assign pop_ready = ~busy;
  assign pop = pop_valid & pop_ready;
  assign pop_tag = pop_data[20:16];
  assign pop_val = pop_data[15:0];
  assign pin_f = pin_cfg_r[gidx_r*3 +: 3];
  // mask of level shifters for the active cells
  assign ls_mask = (17'h00001 << ncell_nxt) - 17'h00001;

  // slot activity and the tag sent with each conversion request
  always @* begin
    slot_act = 1'b0;
    tag = slot_r;
    if (slot_r == `TAG_DIE || slot_r == `TAG_THERMISTOR_BIAS_REF ||
        slot_r == `TAG_BUSBAR)
      slot_act = 1'b1;
    else if (slot_r >= `TAG_CELL_BASE && slot_r < `TAG_BUSBAR)
      slot_act = (slot_r - `TAG_CELL_BASE) < ncell_r;
    else if (slot_r == `SLOT_GPIO) begin
      tag = `TAG_GPIO_BASE + {2'h0, gidx_r};
      slot_act = (pin_f == `PIN_ADC) || (pin_f == `PIN_ADC_LIM);
    end else begin
      // spare slots keep their time but never convert
      slot_act = 1'b0;
    end
  end

  // slot timer: fixed slot length, all slots kept in every cycle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_d_r <= 1'b0;
      cyc_r <= 10'h000;
      slot_r <= 5'h00;
      gidx_r <= 3'h0;
      conv_start <= 1'b0;
      conv_sel <= 5'h00;
      rr_done <= 1'b0;
      ncell_r <= `MAX_CELLS;
      cell_en_r <= 1'b0;
      bb_en_r <= 1'b0;
      cell_sel_r <= 3'h0;
      bb_sel_r <= 3'h0;
      pin_cfg_r <= 24'h000000;
      level_shift_en <= 16'h0000;
    end else begin
      run_d_r <= adc_run;
      conv_start <= 1'b0;
      rr_done <= 1'b0;
      if (pwr_mode == `PWR_ACTIVE)
        level_shift_en <= ls_mask[15:0];
      else
        level_shift_en <= 16'h0000;
      if (start) begin
        ncell_r <= ncell_nxt;
        cell_en_r <= cell_filter_enable;
        bb_en_r <= busbar_filter_enable;
        cell_sel_r <= cell_filter_cutoff_sel;
        bb_sel_r <= busbar_filter_cutoff_sel;
        pin_cfg_r <= pin_config_bank;
        cyc_r <= 10'h000;
        slot_r <= 5'h00;
        gidx_r <= 3'h0;
      end else if (adc_run) begin
        if (cyc_r == 10'h000 && slot_act) begin
          conv_start <= 1'b1;
          conv_sel <= tag;
        end
        if (cyc_r == SLOT_LAST) begin
          cyc_r <= 10'h000;
          if (slot_r == SLOT_END) begin
            slot_r <= 5'h00;
            gidx_r <= gidx_r + 3'h1;
            rr_done <= 1'b1;
          end else begin
            slot_r <= slot_r + 5'h01;
          end
        end else begin
          cyc_r <= cyc_r + 10'h001;
        end
      end
    end
  end

  // results from the converter pass a two-entry buffer
  result_fifo2 #(
    .W(21)
  ) u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data({conv_tag, conv_data}),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // filter selection for the popped word
  always @* begin
    fsel = 1'b0;
    fidx = 5'h00;
    if (pop_tag >= `TAG_CELL_BASE && pop_tag < `TAG_BUSBAR) begin
      fidx = pop_tag - `TAG_CELL_BASE;
      fsel = cell_en_r;
    end else if (pop_tag == `TAG_BUSBAR) begin
      fidx = `IDX_BB;
      fsel = bb_en_r;
    end
  end

  assign f_load = ~primed_r[fidx];
  assign f_sel = (pop_tag == `TAG_BUSBAR) ? bb_sel_r : cell_sel_r;

  lpf_step u_lpf (
    .sample(pop_val),
    .state(flt_r[fidx]),
    .cutoff_sel(f_sel),
    .load(f_load),
    .state_nxt(f_state_nxt),
    .result(f_result)
  );

  // die temperature clamp
  always @* begin
    if ($signed(pop_val) > $signed(`DIE_MAX))
      die_c = `DIE_MAX;
    else if ($signed(pop_val) < $signed(`DIE_MIN))
      die_c = `DIE_MIN;
    else
      die_c = pop_val;
  end

  // result write decode
  always @* begin
    wen = 1'b0;
    widx = 5'h00;
    wval = pop_val;
    if (pop) begin
      if (pop_tag >= `TAG_CELL_BASE && pop_tag < `TAG_BUSBAR) begin
        widx = pop_tag - `TAG_CELL_BASE;
        wen = (widx < ncell_r);
        wval = fsel ? f_result : pop_val;
      end else if (pop_tag == `TAG_BUSBAR) begin
        widx = `IDX_BB;
        wen = 1'b1;
        wval = fsel ? f_result : pop_val;
      end else if (pop_tag == `TAG_DIE) begin
        widx = `IDX_DIE;
        wen = 1'b1;
        wval = die_c;
      end else if (pop_tag == `TAG_THERMISTOR_BIAS_REF) begin
        widx = `IDX_THERMISTOR_BIAS_REF;
        wen = 1'b1;
      end else if (pop_tag >= `TAG_GPIO_BASE) begin
        widx = `IDX_GPIO + {2'h0, pop_tag[2:0]};
        wen = 1'b1;
      end
    end
  end

  // filter states, one per cell channel plus the bus bar
  genvar gf;
  generate
    for (gf = 0; gf < 17; gf = gf + 1) begin : g_flt
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          flt_r[gf] <= 23'h000000;
          primed_r[gf] <= 1'b0;
        end else if (start) begin
          primed_r[gf] <= 1'b0;
        end else if (pop && fsel && fidx == gf && wen) begin
          flt_r[gf] <= f_state_nxt;
          primed_r[gf] <= 1'b1;
        end
      end
    end
  endgenerate

  // result registers with low byte hold after a high byte read
  genvar gr;
  generate
    for (gr = 0; gr < `NUM_RES; gr = gr + 1) begin : g_res
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          res_r[gr] <= `RESULT_DEFAULT;
          lo_r[gr] <= 8'h00;
          frz_r[gr] <= 1'b0;
        end else if (start) begin
          res_r[gr] <= `RESULT_DEFAULT;
          lo_r[gr] <= 8'h00;
          frz_r[gr] <= 1'b0;
        end else begin
          if (wen && widx == gr) begin
            res_r[gr] <= wval;
            if (!frz_r[gr])
              lo_r[gr] <= wval[7:0];
          end
          if (rd_hi && rd_sel == gr) begin
            frz_r[gr] <= 1'b1;
            lo_r[gr] <= res_r[gr][7:0];
          end else if (rd_lo && rd_sel == gr)
            frz_r[gr] <= 1'b0;
        end
      end
    end
  endgenerate

  // read port and die temperature for gain and offset correction
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
      die_corr_temp <= 16'h0000;
    end else begin
      if (wen && widx == `IDX_DIE)
        die_corr_temp <= wval;
      // the byte stands until the next strobe
      if (rd_hi || rd_lo) begin
        if (rd_sel >= `NUM_RES)
          rd_data <= 8'h00;
        else if (rd_hi)
          rd_data <= res_r[rd_sel][15:8];
        else
          rd_data <= frz_r[rd_sel] ? lo_r[rd_sel] : res_r[rd_sel][7:0];
      end
    end
  end
endmodule

// ===== verification/cell_measure_lpf_slots_props.sv
// assertion checker on the slot logic ports
`timescale 1ns/1ps
module cell_measure_lpf_slots_props (
  input wire ref_clk,
  input wire arst_n,
  input wire adc_run,
  input wire [1:0] pwr_mode,
  input wire [3:0] highest_cell_count,
  input wire [23:0] pin_config_bank,
  input wire conv_start,
  input wire [4:0] conv_sel,
  input wire conv_ready,
  input wire [4:0] rd_sel,
  input wire rd_hi,
  input wire [7:0] rd_data,
  input wire [15:0] level_shift_en,
  input wire [15:0] die_corr_temp,
  input wire rr_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  reg [15:0] gap_r;
  reg seen_r;
  wire [4:0] top_cell;
  wire [4:0] pin_idx;
  reg [4:0] top_cell_r;
  reg [23:0] pin_cfg_r;
  reg run_q;
  assign top_cell = (highest_cell_count == 4'h0) ? 5'h10 :
    (highest_cell_count < 4'h6) ? 5'h06 : {1'b0, highest_cell_count};
  assign pin_idx = conv_sel - 5'h18;
  // cycles since the last conversion request of this run
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else if (!adc_run) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else if (conv_start) begin
      gap_r <= 16'h0001;
      seen_r <= 1'b1;
    end else if (gap_r != 16'hFFFF) begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  // configuration as the design takes it at each start edge
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      top_cell_r <= 5'h10;
      pin_cfg_r <= 24'h000000;
    end else begin
      run_q <= adc_run;
      if (adc_run && !run_q) begin
        top_cell_r <= top_cell;
        pin_cfg_r <= pin_config_bank;
      end
    end
  end
  chk_start_single: assert property (conv_start |=> !conv_start)
    else $error("conversion request wider than one cycle");
  chk_slot_grid: assert property (conv_start && seen_r |->
    (gap_r % 16'h0320) == 16'h0000)
    else $error("conversion request off the slot grid");
  chk_sel_hold: assert property (!conv_start |-> $stable(conv_sel))
    else $error("input select moved without a request");
  chk_active_cell: assert property (conv_start && conv_sel >= 5'h02 &&
    conv_sel <= 5'h11 |-> (conv_sel - 5'h02) < top_cell_r)
    else $error("inactive cell slot converted");
  chk_pin_enabled: assert property (conv_start && conv_sel >= 5'h18 |->
    pin_cfg_r[pin_idx * 3 +: 3] inside {3'h4, 3'h5})
    else $error("unconfigured pin converted");
  chk_sleep_off: assert property ((pwr_mode != 2'h0) [*3] |->
    level_shift_en == 16'h0000)
    else $error("level shifters on outside active mode");
  chk_die_range: assert property ($signed(die_corr_temp) <=
    $signed(16'h1F40) && $signed(die_corr_temp) >= $signed(16'hF060))
    else $error("die temperature outside clamp range");
  chk_bad_index: assert property (rd_hi && rd_sel >= 5'h1B |=>
    rd_data == 8'h00)
    else $error("unmapped result index read nonzero");
  cov_pin_slot: cover property (conv_start && conv_sel == 5'h1A);
  cov_buffer_full: cover property (!conv_ready);
  cov_cycle_end: cover property (rr_done);
endmodule
bind cell_measure_lpf_slots cell_measure_lpf_slots_props u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .adc_run(adc_run),
  .pwr_mode(pwr_mode), .highest_cell_count(highest_cell_count),
  .pin_config_bank(pin_config_bank), .conv_start(conv_start),
  .conv_sel(conv_sel), .conv_ready(conv_ready), .rd_sel(rd_sel),
  .rd_hi(rd_hi), .rd_data(rd_data), .level_shift_en(level_shift_en),
  .die_corr_temp(die_corr_temp), .rr_done(rr_done)
);

// ===== verification/cell_measure_lpf_slots_bench.sv
// self-checking bench for the cell measurement slot logic
`timescale 1ns/1ps
module cell_measure_lpf_slots_bench;
  reg ref_clk, arst_n, adc_run, cell_filter_enable, busbar_filter_enable;
  reg rd_hi, rd_lo, conv_valid, low_seen;
  reg [1:0] pwr_mode;
  reg [3:0] highest_cell_count;
  reg [2:0] cell_filter_cutoff_sel, busbar_filter_cutoff_sel;
  reg [23:0] pin_config_bank;
  reg [4:0] conv_tag, rd_sel;
  reg [15:0] conv_data;
  reg [7:0] hb;
  wire conv_start, conv_ready, rr_done;
  wire [4:0] conv_sel;
  wire [7:0] rd_data;
  wire [15:0] level_shift_en, die_corr_temp;
  integer err_count, checks, np, nd, ncyc, s, k, r;
  integer pt [0:63];
  reg [4:0] ps [0:63];
  cell_measure_lpf_slots u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .adc_run(adc_run),
    .pwr_mode(pwr_mode), .highest_cell_count(highest_cell_count),
    .cell_filter_cutoff_sel(cell_filter_cutoff_sel),
    .cell_filter_enable(cell_filter_enable),
    .busbar_filter_cutoff_sel(busbar_filter_cutoff_sel),
    .busbar_filter_enable(busbar_filter_enable),
    .pin_config_bank(pin_config_bank), .conv_start(conv_start),
    .conv_sel(conv_sel), .conv_valid(conv_valid), .conv_tag(conv_tag),
    .conv_data(conv_data), .conv_ready(conv_ready), .rd_sel(rd_sel),
    .rd_hi(rd_hi), .rd_lo(rd_lo), .rd_data(rd_data),
    .level_shift_en(level_shift_en), .die_corr_temp(die_corr_temp),
    .rr_done(rr_done)
  );
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  // records request times and inputs away from the sampling edge
  always @(negedge ref_clk) begin
    ncyc = ncyc + 1;
    if (conv_start === 1'b1 && np < 64) begin
      pt[np] = ncyc;
      ps[np] = conv_sel;
      np = np + 1;
    end
    if (rr_done === 1'b1) nd = nd + 1;
    if (conv_ready === 1'b0) low_seen = 1;
  end
  task automatic tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task chk(input [8*16:1] nm, input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (e !== g) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task send(input [4:0] t, input [15:0] d);
    reg ok;
    integer n;
    begin
      conv_valid = 1;
      conv_tag = t;
      conv_data = d;
      ok = 0;
      n = 0;
      while (!ok && n < 50) begin
        ok = (conv_ready === 1'b1);
        tick(1);
        n = n + 1;
      end
      conv_valid = 0;
      if (!ok)
        chk("conv_ready", 16'h0001, 16'h0000);
      tick(1);
    end
  endtask
  // high then low byte; optionally a new cell 1 word in between
  task rd(input [4:0] i, input [15:0] e, input m, input [15:0] w);
    begin
      rd_sel = i;
      rd_hi = 1;
      tick(1);
      rd_hi = 0;
      tick(1);
      hb = rd_data;
      if (m) begin
        send(5'h02, w);
        tick(3);
      end
      rd_lo = 1;
      tick(1);
      rd_lo = 0;
      tick(1);
      chk("result", e, {hb, rd_data});
    end
  endtask
  task die(input [15:0] d, input [15:0] e);
    begin
      send(5'h00, d);
      tick(3);
      rd(5'h11, e, 0, 16'h0000);
      chk("die_corr_temp", e, die_corr_temp);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    err_count = err_count + 1;
    finish_test;
  end
  initial begin
    err_count = 0;
    checks = 0;
    np = 0;
    nd = 0;
    ncyc = 0;
    low_seen = 0;
    {arst_n, adc_run, rd_hi, rd_lo, conv_valid} = 5'h00;
    {cell_filter_enable, busbar_filter_enable, pwr_mode} = 4'h0;
    {cell_filter_cutoff_sel, busbar_filter_cutoff_sel} = 6'h00;
    {conv_tag, rd_sel, conv_data} = 26'h0000000;
    highest_cell_count = 4'h6;
    pin_config_bank = 24'h000144;
    repeat (8) @(posedge ref_clk);
    #1;
    arst_n = 1;
    tick(2);
    rd(5'h00, 16'h8000, 0, 16'h0000);
    $display("test reset defaults done");
    adc_run = 1;
    tick(3);
    send(5'h02, 16'h1234);
    send(5'h09, 16'h5555);
    send(5'h12, 16'hFEDC);
    send(5'h18, 16'h0ABC);
    tick(3);
    rd(5'h00, 16'h1234, 0, 16'h0000);
    rd(5'h07, 16'h8000, 0, 16'h0000);
    rd(5'h10, 16'hFEDC, 0, 16'h0000);
    rd(5'h12, 16'h0ABC, 0, 16'h0000);
    rd(5'h1B, 16'h0000, 0, 16'h0000);
    rd(5'h00, 16'h1234, 1, 16'h2222);
    rd(5'h00, 16'h2222, 0, 16'h0000);
    chk("level_shift_en", 16'h003F, level_shift_en);
    die(16'h0100, 16'h0100);
    die(16'h1F41, 16'h1F40);
    die(16'hF05F, 16'hF060);
    low_seen = 0;
    fork
      begin
        rd_sel = 5'h1B;
        rd_hi = 1;
        tick(6);
        rd_hi = 0;
      end
      begin
        send(5'h02, 16'h0001);
        send(5'h03, 16'h0002);
        send(5'h04, 16'h0003);
      end
    join
    tick(3);
    chk("buffer full", 16'h0001, {15'h0000, low_seen});
    rd(5'h00, 16'h0001, 0, 16'h0000);
    rd(5'h01, 16'h0002, 0, 16'h0000);
    rd(5'h02, 16'h0003, 0, 16'h0000);
    $display("test raw results done");
    k = 0;
    while (nd < 3 && k < 70000) begin
      tick(1);
      k = k + 1;
    end
    chk("rr_done count", 16'h0003, nd[15:0]);
    k = 0;
    for (r = 0; r < 3; r = r + 1)
      for (s = 0; s < 20; s = s + 1)
        if (s < 8 || s == 18 || (s == 19 && r != 1)) begin
          chk("slot time", 16'(r * 19200 + s * 800), 16'(pt[k] - pt[0]));
          chk("slot input", 16'(s < 19 ? s : 24 + r), {11'h000, ps[k]});
          k = k + 1;
        end
    pwr_mode = 2'h1;
    tick(4);
    chk("level_shift_en", 16'h0000, level_shift_en);
    pwr_mode = 2'h0;
    highest_cell_count = 4'h0;
    tick(2);
    chk("level_shift_en", 16'hFFFF, level_shift_en);
    highest_cell_count = 4'h3;
    tick(2);
    chk("level_shift_en", 16'h003F, level_shift_en);
    highest_cell_count = 4'h6;
    $display("test slot sequence done");
    for (s = 0; s < 8; s = s + 1) begin
      adc_run = 0;
      cell_filter_cutoff_sel = s[2:0];
      cell_filter_enable = (s < 7);
      busbar_filter_enable = (s == 7);
      busbar_filter_cutoff_sel = 3'h1;
      tick(2);
      adc_run = 1;
      tick(3);
      send(5'h02, 16'h4000);
      send(5'h03, 16'h4000);
      send(5'h12, 16'h4000);
      tick(3);
      rd(5'h00, 16'h4000, 0, 16'h0000);
      send(5'h02, 16'h0000);
      send(5'h03, 16'h0000);
      send(5'h12, 16'h0000);
      tick(3);
      if (s < 7) begin
        rd(5'h00, 16'h4000 - (16'h4000 >> (s + 1)), 0, 16'h0000);
        rd(5'h01, 16'h4000 - (16'h4000 >> (s + 1)), 0, 16'h0000);
        rd(5'h10, 16'h0000, 0, 16'h0000);
      end else begin
        rd(5'h10, 16'h3000, 0, 16'h0000);
        rd(5'h00, 16'h0000, 0, 16'h0000);
      end
    end
    $display("test filters done");
    finish_test;
  end
endmodule
